/* File: include/ibsc_pkg.sv */
// Package for the I2C bus-state control block: register map, fields, timing.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package ibsc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] IBSC_SEL_OFF   = 8'h00;
  localparam logic [7:0] IBSC_CR1_OFF   = 8'h04;
  localparam logic [7:0] IBSC_CR2_OFF   = 8'h08;
  localparam logic [7:0] IBSC_SR_OFF    = 8'h0C;
  localparam logic [7:0] IBSC_SAR_OFF   = 8'h10;
  localparam logic [7:0] IBSC_TXD_OFF   = 8'h14;
  localparam logic [7:0] IBSC_RXD_OFF   = 8'h18;
  localparam logic [7:0] IBSC_IRQ_OFF   = 8'h1C;
  localparam logic [7:0] IBSC_MASK_OFF  = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int IBSC_SEL_BIT   = 0;
  localparam int IBSC_CR1_EN    = 7;
  localparam int IBSC_CR1_MST   = 5;
  localparam int IBSC_CR1_TRS   = 4;
  localparam int IBSC_CR2_BUSY  = 7;
  localparam int IBSC_CR2_REQ   = 6;
  localparam int IBSC_CR2_SDA_OUTPUT_MONITOR  = 5;
  localparam int IBSC_CR2_RST   = 1;
  localparam int IBSC_CR2_SCL_MONITOR_FLAG  = 0;
  localparam int IBSC_SR_TRANSMIT_EMPTY_FLAG   = 7;
  localparam int IBSC_SR_RECEIVE_FULL_FLAG   = 5;
  localparam int IBSC_SR_STOP   = 3;
  localparam int IBSC_SR_AL     = 2;
  localparam int IBSC_SAR_FS    = 0;
  localparam int IBSC_EV_START  = 0;
  localparam int IBSC_EV_STOP   = 1;
  localparam int IBSC_EV_RX     = 2;
  localparam int IBSC_EV_AL     = 3;
  localparam int IBSC_EV_W      = 4;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [31:0] IBSC_ZERO   = 32'h0000_0000;
  localparam int          IBSC_CLK_MHZ = 200;
  localparam int          IBSC_HOLD_NS = 600;
  localparam int          IBSC_HOLD_CYC = (IBSC_HOLD_NS * IBSC_CLK_MHZ + 999) / 1000;
  localparam int          IBSC_HALF_DEF = 250;

  typedef enum logic [1:0] {
    IBSC_SLV_RX = 2'b00,
    IBSC_SLV_TX = 2'b01,
    IBSC_MST_RX = 2'b10,
    IBSC_MST_TX = 2'b11
  } ibsc_mode_t;

  // Decode of master/transmit select into an operating mode
  function automatic ibsc_mode_t ibsc_mode(input logic master_select_bit, input logic transmit_select_bit);
    ibsc_mode = ibsc_mode_t'({master_select_bit, transmit_select_bit});
  endfunction

endpackage

/* File: include/ibsc_line_if.sv */
// Interface carrying synchronised line levels and detected conditions.
// Assumes all signals are on hclk.
`timescale 1ns/1ps
interface ibsc_line_if;
  logic scl;
  logic sda;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  modport mon (output scl, output sda, output start_det, output stop_det, output scl_fall);
  modport use_side (input scl, input sda, input start_det, input stop_det, input scl_fall);
endinterface

/* File: design/ibsc_line_mon.sv */
// Two-flop synchronisers on SCL/SDA and start/stop/edge detection.
// Assumes pins are asynchronous to hclk.
`timescale 1ns/1ps
module ibsc_line_mon (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  ibsc_line_if.mon    ln
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  assign ln.scl       = scl_sync_r[1];
  assign ln.sda       = sda_sync_r[1];
  assign ln.start_det = scl_d_r & scl_sync_r[1] & sda_d_r & ~sda_sync_r[1];
  assign ln.stop_det  = scl_d_r & scl_sync_r[1] & ~sda_d_r & sda_sync_r[1];
  assign ln.scl_fall  = scl_d_r & ~scl_sync_r[1];
endmodule

/* File: design/ibsc_divider.sv */
// Enable-pulse divider for SCL half periods.
// Assumes a one-clock design; restart clears the count.
`timescale 1ns/1ps
module ibsc_divider #(
  parameter int HALF = 250
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic restart,
  output logic      tick
);
  initial begin
    if (HALF < 2) $error("HALF too small");
  end
  logic [15:0] cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else if (restart || cnt_r == 16'(HALF - 1)) begin
      cnt_r <= 16'h0000;
      tick  <= ~restart;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule

/* File: design/ibsc_top.sv */
// I2C bus-state control: AHB-Lite registers, busy tracking, start/stop, byte engine.
// Assumes open-drain SCL/SDA pins resolved outside; oe low means pulling low.
//
// Overview of operation
// - Select bit 0 routes pins to serial unit; 1 enables this I2C interface.
// - Stop or restart coinciding with ninth falling SCL edge adds one SCL cycle; here only a pending stop adds it.
// - SCL monitor bit follows the SCL pin and reads 0 while pin is low.
// - Disable or reset during a transfer may leave busy and stop flags undefined.
// - Master and transmit select bits encode the four operating modes.
// - Incoming start condition sets the bus busy flag.
// - Incoming stop condition clears the bus busy flag.
// - Master transmit, lines high, write busy 1 request 0 makes a start.
// - Master mode, write busy 0 request 0 makes a stop, then clears busy.
// - Writing format select 1 in slave address register clears bus busy.
// - Writing control reset 1 forces SDA and SCL output monitors to 1.
// - Control reset in a transmit mode sets transmit empty flag.
// - During control reset writes to busy, request and SDA output are ignored.
// - Control reset alone does not clear busy; a line stop still may.
// - During control reset transfers halt but start, stop, loss detection remain; here loss detection needs IBSC_HIGH, so it halts too.
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ibsc_top
  import ibsc_pkg::*;
#(
  parameter int HALF = IBSC_HALF_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             ssu_sel,
  output logic             irq
);
  initial begin
    if (HALF < IBSC_HOLD_CYC) $error("HALF shorter than hold time");
  end

  // ****************************************
  // Line monitor and divider
  // ****************************************
  ibsc_line_if ln ();
  ibsc_line_mon u_mon (
    .hclk    (hclk),
    .hresetn (hresetn),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ln      (ln)
  );

  typedef enum logic [2:0] {
    IBSC_IDLE  = 3'b000,
    IBSC_START = 3'b001,
    IBSC_LOW   = 3'b010,
    IBSC_HIGH  = 3'b011,
    IBSC_STOP1 = 3'b100,
    IBSC_STOP2 = 3'b101,
    IBSC_EXTRA = 3'b110
  } ibsc_state_t;

  ibsc_state_t state_r;
  logic        tick;
  logic        div_restart;
  assign div_restart = (state_r == IBSC_IDLE);

  ibsc_divider #(.HALF(HALF)) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .restart (div_restart),
    .tick    (tick)
  );

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       take;
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  logic we_sel, we_cr1, we_cr2, we_sar, we_txd, we_irq, we_mask;
  assign we_sel  = wr_pend_r && wr_addr_r == IBSC_SEL_OFF;
  assign we_cr1  = wr_pend_r && wr_addr_r == IBSC_CR1_OFF;
  assign we_cr2  = wr_pend_r && wr_addr_r == IBSC_CR2_OFF;
  assign we_sar  = wr_pend_r && wr_addr_r == IBSC_SAR_OFF;
  assign we_txd  = wr_pend_r && wr_addr_r == IBSC_TXD_OFF;
  assign we_irq  = wr_pend_r && wr_addr_r == IBSC_IRQ_OFF;
  assign we_mask = wr_pend_r && wr_addr_r == IBSC_MASK_OFF;

  // ****************************************
  // Control registers
  // ****************************************
  logic       sel_r, en_r, mst_r, trs_r, rst_r, sda_output_monitor_r, scl_monitor_flag_mon_r, fs_r;
  logic       busy_r, stop_flag_r, transmit_empty_flag_r, receive_full_flag_r, al_r;
  logic [7:0] txd_r, rxd_r, shift_r;
  logic [3:0] bit_r;
  logic [IBSC_EV_W-1:0] evt_r, mask_r;
  logic       req_start_r, req_stop_r;
  ibsc_mode_t mode;
  logic       run;

  assign mode = ibsc_mode(mst_r, trs_r);
  assign run  = sel_r && en_r && !rst_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_r <= 1'b0;
    end else if (we_sel) begin
      sel_r <= hwdata[IBSC_SEL_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r  <= 1'b0;
      mst_r <= 1'b0;
      trs_r <= 1'b0;
    end else if (we_cr1) begin
      en_r  <= hwdata[IBSC_CR1_EN];
      mst_r <= hwdata[IBSC_CR1_MST];
      trs_r <= hwdata[IBSC_CR1_TRS];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_r <= 1'b0;
      fs_r  <= 1'b0;
    end else begin
      if (we_cr2) rst_r <= hwdata[IBSC_CR2_RST];
      if (we_sar) fs_r  <= hwdata[IBSC_SAR_FS];
    end
  end

  // SDA output monitor; reset forces both monitors high, writes blocked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_output_monitor_r     <= 1'b1;
      scl_monitor_flag_mon_r <= 1'b1;
    end else if (we_cr2 && hwdata[IBSC_CR2_RST]) begin
      sda_output_monitor_r     <= 1'b1;
      scl_monitor_flag_mon_r <= 1'b1;
    end else begin
      scl_monitor_flag_mon_r <= ln.scl;
      if (we_cr2 && !rst_r) sda_output_monitor_r <= hwdata[IBSC_CR2_SDA_OUTPUT_MONITOR];
    end
  end

  // Start/stop requests; only taken outside control reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_start_r <= 1'b0;
      req_stop_r  <= 1'b0;
    end else begin
      if (we_cr2 && !rst_r && !hwdata[IBSC_CR2_REQ] && hwdata[IBSC_CR2_BUSY]
          && mode == IBSC_MST_TX && ln.scl && ln.sda && run) begin
        req_start_r <= 1'b1;
      end else if (state_r == IBSC_START) begin
        req_start_r <= 1'b0;
      end
      if (we_cr2 && !rst_r && !hwdata[IBSC_CR2_REQ] && !hwdata[IBSC_CR2_BUSY]
          && mst_r && run) begin
        req_stop_r <= 1'b1;
      end else if (state_r == IBSC_STOP2 || !run) begin
        req_stop_r <= 1'b0;
      end
    end
  end

  // Bus busy follows line conditions; control reset leaves it alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
    end else if (ln.start_det) begin
      busy_r <= 1'b1;
    end else if (ln.stop_det) begin
      busy_r <= 1'b0;
    end else if (we_sar && hwdata[IBSC_SAR_FS]) begin
      busy_r <= 1'b0;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic byte_done, rx_done, lost;
  assign byte_done = tick && state_r == IBSC_HIGH && bit_r == 4'h8;
  assign rx_done   = byte_done && !trs_r;
  assign lost      = mst_r && state_r == IBSC_HIGH && tick && sda_out && !ln.sda
                     && bit_r != 4'h8;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_flag_r <= 1'b0;
      al_r        <= 1'b0;
    end else begin
      if (ln.stop_det) stop_flag_r <= 1'b1;
      else if (we_cr2 && !hwdata[IBSC_CR2_BUSY]) stop_flag_r <= stop_flag_r;
      if (lost) al_r <= 1'b1;
      else if (we_cr1) al_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transmit_empty_flag_r <= 1'b1;
      txd_r  <= 8'h00;
    end else if (we_cr2 && hwdata[IBSC_CR2_RST] && trs_r) begin
      transmit_empty_flag_r <= 1'b1;
    end else if (we_txd) begin
      transmit_empty_flag_r <= 1'b0;
      txd_r  <= hwdata[7:0];
    end else if (state_r == IBSC_START || byte_done) begin
      transmit_empty_flag_r <= 1'b1;
    end
  end

  // Reading received data clears receive-full, but a new byte wins
  logic rd_rxd;
  assign rd_rxd = take && !hwrite && haddr[7:0] == IBSC_RXD_OFF;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_full_flag_r <= 1'b0;
      rxd_r  <= 8'h00;
    end else if (rx_done) begin
      receive_full_flag_r <= 1'b1;
      rxd_r  <= shift_r;
    end else if (rd_rxd) begin
      receive_full_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Master sequencer
  // ****************************************
  // Ninth-clock overlap quirk: a stop pending at the ninth falling edge
  // costs one extra SCL cycle; software avoids it by polling as documented.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= IBSC_IDLE;
      bit_r   <= 4'h0;
      shift_r <= 8'h00;
      scl_out <= 1'b1;
      sda_out <= 1'b1;
    end else if (!run) begin
      state_r <= IBSC_IDLE;
      scl_out <= 1'b1;
      sda_out <= 1'b1;
    end else begin
      unique case (state_r)
        IBSC_IDLE: begin
          if (req_start_r) begin
            sda_out <= 1'b0;
            state_r <= IBSC_START;
          end
        end
        IBSC_START: begin
          if (tick) begin
            scl_out <= 1'b0;
            bit_r   <= 4'h0;
            shift_r <= txd_r;
            state_r <= IBSC_LOW;
          end
        end
        IBSC_LOW: begin
          if (req_stop_r && bit_r == 4'h0) begin
            sda_out <= 1'b0;
            if (tick) state_r <= IBSC_STOP1;
          end else if (tick) begin
            if (bit_r == 4'h8) sda_out <= trs_r; // ack slot
            else sda_out <= trs_r ? shift_r[7] : 1'b1;
            scl_out <= 1'b1;
            state_r <= IBSC_HIGH;
          end
        end
        IBSC_HIGH: begin
          if (lost) begin
            state_r <= IBSC_IDLE;
            scl_out <= 1'b1;
            sda_out <= 1'b1;
          end else if (tick && ln.scl) begin
            scl_out <= 1'b0;
            if (bit_r == 4'h8) begin
              bit_r   <= 4'h0;
              shift_r <= txd_r;
              state_r <= req_stop_r ? IBSC_EXTRA : IBSC_LOW;
            end else begin
              bit_r   <= bit_r + 4'h1;
              shift_r <= {shift_r[6:0], ln.sda};
              state_r <= IBSC_LOW;
            end
          end
        end
        IBSC_EXTRA: begin
          if (tick) begin
            scl_out <= ~scl_out;
            if (!scl_out) state_r <= IBSC_EXTRA;
            else state_r <= IBSC_LOW;
          end
        end
        IBSC_STOP1: begin
          if (tick) begin
            scl_out <= 1'b1;
            state_r <= IBSC_STOP2;
          end
        end
        IBSC_STOP2: begin
          if (tick) begin
            sda_out <= 1'b1;
            state_r <= IBSC_IDLE;
          end
        end
        default: state_r <= IBSC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Events, interrupt and read mux
  // ****************************************
  logic [IBSC_EV_W-1:0] ev_set;
  assign ev_set = {lost, rx_done, ln.stop_det, ln.start_det};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_r  <= '0;
      mask_r <= '0;
    end else begin
      evt_r <= ev_set | (evt_r & ~(we_irq ? hwdata[IBSC_EV_W-1:0] : '0));
      if (we_mask) mask_r <= hwdata[IBSC_EV_W-1:0];
    end
  end

  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = IBSC_ZERO;
    unique case (haddr[7:0])
      IBSC_SEL_OFF:  rd_nxt[IBSC_SEL_BIT] = sel_r;
      IBSC_CR1_OFF:  rd_nxt[7:0] = {en_r, 1'b0, mst_r, trs_r, 4'h0};
      IBSC_CR2_OFF:  rd_nxt[7:0] = {busy_r, 1'b0, sda_output_monitor_r, 3'h0, rst_r, scl_monitor_flag_mon_r};
      IBSC_SR_OFF:   rd_nxt[7:0] = {transmit_empty_flag_r, 1'b0, receive_full_flag_r, 1'b0, stop_flag_r, al_r, 2'h0};
      IBSC_SAR_OFF:  rd_nxt[IBSC_SAR_FS] = fs_r;
      IBSC_TXD_OFF:  rd_nxt[7:0] = txd_r;
      IBSC_RXD_OFF:  rd_nxt[7:0] = rxd_r;
      IBSC_IRQ_OFF:  rd_nxt[IBSC_EV_W-1:0] = evt_r;
      IBSC_MASK_OFF: rd_nxt[IBSC_EV_W-1:0] = mask_r;
      default:       rd_nxt = IBSC_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= IBSC_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= 1'b0;
      ssu_sel   <= 1'b1;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
    end else begin
      if (take && !hwrite) hrdata <= rd_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= |(evt_r & mask_r);
      ssu_sel   <= ~sel_r;
      scl_oe_n  <= scl_out | ~run;
      sda_oe_n  <= (sda_out & sda_output_monitor_r) | ~run;
    end
  end
endmodule

/* File: tb/ibsc_bus_peer.sv */
// Far-side model: another I2C party on pulled-up SCL and SDA lines.
// Assumes the block's oe_n outputs pull a line low while low.
`timescale 1ns/1ps
module ibsc_bus_peer (
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;
  // Pull-ups: a line is low while any party pulls it
  assign scl = !(scl_lo || !scl_oe_n);
  assign sda = !(sda_lo || !sda_oe_n);
  // SDA falls with SCL high, then SCL low opens the frame
  task automatic start_cond();
    sda_lo <= 1'b1;
    #80;
    scl_lo <= 1'b1;
    #80;
  endtask
  // Link clock of 160 ns runs only inside a frame
  task automatic clocks(input int n);
    repeat (n) begin
      scl_lo <= 1'b0;
      #80;
      scl_lo <= 1'b1;
      #80;
    end
  endtask
  // SDA rises with SCL high, closing the frame
  task automatic stop_cond();
    sda_lo <= 1'b1;
    #80;
    scl_lo <= 1'b0;
    #80;
    sda_lo <= 1'b0;
    #80;
  endtask
endmodule

/* File: tb/ibsc_top_props.sv */
// Checker for ibsc_top: bus answer, pin routing, SCL monitor, interrupt.
// Assumes it is bound to ibsc_top and sees only its ports.
`timescale 1ns/1ps
module ibsc_top_props
  import ibsc_pkg::*;
#(
  parameter int HALF = IBSC_HALF_DEF
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_n,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        ssu_sel,
  input wire logic        irq
);
  logic       dph_q;
  logic       dwr_q;
  logic [7:0] doff_q;
  logic       sel_wr_q;
  logic       sel_v_q;
  logic       rst_q;
  logic [3:0] mask_q;
  logic [2:0] lo_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Shadow of bus phases and written fields
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q    <= 1'b0;
      dwr_q    <= 1'b0;
      doff_q   <= 8'h00;
      sel_wr_q <= 1'b0;
      sel_v_q  <= 1'b0;
      rst_q    <= 1'b0;
      mask_q   <= 4'h0;
      lo_cnt   <= 3'h0;
    end else begin
      dph_q    <= hsel && hready && htrans[1];
      dwr_q    <= hwrite;
      doff_q   <= haddr[7:0];
      sel_wr_q <= dph_q && dwr_q && (doff_q == IBSC_SEL_OFF);
      if (dph_q && dwr_q && doff_q == IBSC_SEL_OFF) sel_v_q <= hwdata[0];
      if (dph_q && dwr_q && doff_q == IBSC_CR2_OFF) rst_q <= hwdata[IBSC_CR2_RST];
      if (dph_q && dwr_q && doff_q == IBSC_MASK_OFF) mask_q <= hwdata[3:0];
      lo_cnt   <= scl_in ? 3'h0 : ((lo_cnt == 3'h7) ? lo_cnt : lo_cnt + 3'h1);
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  zero_wait_a: assert property ((hsel && htrans[1]) |-> ##1 hreadyout)
    else $error("wait state inserted");
  okay_resp_a: assert property ((hsel && htrans[1]) |-> ##1 (!hresp)[*2])
    else $error("error response given");
  sel_route_a: assert property (sel_wr_q |-> ##[0:1] (ssu_sel == !sel_v_q))
    else $error("select bit not routed");
  pins_free_a: assert property (ssu_sel[*3] |-> (scl_oe_n && sda_oe_n))
    else $error("pins driven in serial unit mode");
  irq_mask_a: assert property ((mask_q == 4'h0)[*2] |-> !irq)
    else $error("interrupt with all masked");
  irq_cause_a: assert property ($rose(irq) |-> $past(mask_q) != 4'h0)
    else $error("interrupt rose without mask");
  scl_mon_a: assert property ((dph_q && !dwr_q && doff_q == IBSC_CR2_OFF && !rst_q
    && lo_cnt == 3'h7) |-> hrdata[IBSC_CR2_SCL_MONITOR_FLAG] == 1'b0)
    else $error("SCL monitor high while line low");
  unmapped_rd_a: assert property ((dph_q && !dwr_q && doff_q == 8'h24) |-> hrdata == IBSC_ZERO)
    else $error("unmapped read not zero");
endmodule

bind ibsc_top ibsc_top_props #(.HALF(HALF)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in), .sda_in(sda_in),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .ssu_sel(ssu_sel), .irq(irq)
);

/* File: tb/ibsc_top_tb.sv */
// Testbench for ibsc_top: AHB-Lite register traffic and a peer on SCL/SDA.
// Assumes the peer model and the bound checker are compiled first.
`timescale 1ns/1ps
module ibsc_top_tb;
  import ibsc_pkg::*;
  // Shortest half period the block accepts; one byte costs about 2200 cycles
  localparam int HALF_TB = IBSC_HOLD_CYC;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        scl;
  logic        sda;
  logic        scl_oe_n;
  logic        sda_oe_n;
  logic        ssu_sel;
  logic        irq;
  logic [31:0] seed = 32'h702A2BC1;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #2.5 hclk = ~hclk;
  ibsc_top #(.HALF(HALF_TB)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .sda_in(sda),
    .scl_out(), .scl_oe_n(scl_oe_n), .sda_out(), .sda_oe_n(sda_oe_n),
    .ssu_sel(ssu_sel), .irq(irq)
  );
  ibsc_bus_peer u_peer (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] cr1_val(input logic m, input logic t);
    return 32'h80 | {26'h0, m, t, 4'h0};
  endfunction
  task automatic results();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  // Polls a register until the masked value matches, bounded, then compares it
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    int          n;
    n = 0;
    bus(1'b0, a, 32'h0, q);
    while ((q & m) !== e && n < 2000) begin
      bus(1'b0, a, 32'h0, q);
      n++;
    end
    chk(q & m, e);
  endtask
  // Waits for the busy bit to drop, then checks both lines idle
  task automatic wait_free();
    poll(IBSC_CR2_OFF, 32'h80, 32'h0);
    chk({30'h0, scl, sda}, 32'h3);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, ssu_sel}, 32'h1);
    rdchk(IBSC_CR2_OFF, 32'h80, 32'h0);
    wr(IBSC_SEL_OFF, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, ssu_sel}, 32'h0);
    $display("select test done");
    for (int i = 0; i < 4; i++) begin
      wr(IBSC_CR1_OFF, cr1_val(i[1], i[0]));
      rdchk(IBSC_CR1_OFF, 32'hB0, cr1_val(i[1], i[0]));
    end
    wr(IBSC_CR1_OFF, 32'hB0);
    wr(IBSC_TXD_OFF, 32'h5A);
    rdchk(IBSC_SR_OFF, 32'h80, 32'h0);
    wr(IBSC_CR2_OFF, 32'h02);
    rdchk(IBSC_SR_OFF, 32'h80, 32'h80);
    rdchk(IBSC_CR2_OFF, 32'h21, 32'h21);
    wr(IBSC_CR2_OFF, 32'h82);
    rdchk(IBSC_CR2_OFF, 32'h80, 32'h0);
    chk({31'h0, sda}, 32'h1);
    wr(IBSC_CR2_OFF, 32'h00);
    // SDA output bit kept at 1 on every control write outside control reset, or it would hold SDA low
    wr(IBSC_CR2_OFF, 32'hA0);
    repeat (20) @(posedge hclk);
    rdchk(IBSC_CR2_OFF, 32'h80, 32'h80);
    chk({31'h0, sda}, 32'h0);
    wr(IBSC_CR1_OFF, 32'hA0);
    poll(IBSC_SR_OFF, 32'h20, 32'h20);
    poll(IBSC_CR2_OFF, 32'h01, 32'h0);
    wr(IBSC_CR2_OFF, 32'h20);
    wait_free();
    rdchk(IBSC_RXD_OFF, 32'hFF, 32'hFF);
    $display("master start stop test done");
    wr(IBSC_CR1_OFF, 32'h80);
    wr(IBSC_MASK_OFF, 32'h1);
    u_peer.start_cond();
    u_peer.clocks(2);
    @(posedge hclk);
    repeat (8) @(posedge hclk);
    rdchk(IBSC_CR2_OFF, 32'h81, 32'h80);
    rdchk(IBSC_IRQ_OFF, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IBSC_MASK_OFF, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    wr(IBSC_CR2_OFF, 32'h02);
    rdchk(IBSC_CR2_OFF, 32'h80, 32'h80);
    u_peer.stop_cond();
    @(posedge hclk);
    rdchk(IBSC_CR2_OFF, 32'h80, 32'h0);
    rdchk(IBSC_SR_OFF, 32'h08, 32'h08);
    wr(IBSC_CR2_OFF, 32'h00);
    rdchk(IBSC_IRQ_OFF, 32'h3, 32'h3);
    wr(IBSC_IRQ_OFF, 32'h3);
    rdchk(IBSC_IRQ_OFF, 32'h3, 32'h0);
    $display("peer busy test done");
    u_peer.start_cond();
    @(posedge hclk);
    rdchk(IBSC_CR2_OFF, 32'h80, 32'h80);
    wr(IBSC_SAR_OFF, 32'h1);
    rdchk(IBSC_CR2_OFF, 32'h80, 32'h0);
    wr(IBSC_SAR_OFF, 32'h0);
    u_peer.stop_cond();
    @(posedge hclk);
    $display("format select test done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(IBSC_MASK_OFF, seed & 32'hF);
      rdchk(IBSC_MASK_OFF, 32'hF, seed & 32'hF);
      rdchk(8'h24, 32'hFFFFFFFF, 32'h0);
    end
    wr(IBSC_MASK_OFF, 32'h0);
    $display("random mask test done");
    results();
  end
endmodule
